// *** cpp_pkg.sv ***
// shared constants for the link-parameter and pin-function command block
package cpp_pkg;

    // ------------------------------------------------------------------
    // character codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_W = 8'h57;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_ESC = 8'h24;

    // ------------------------------------------------------------------
    // command layout
    // ------------------------------------------------------------------
    localparam logic [2:0] LINK_DIGITS = 3'h4;
    localparam logic [2:0] PIN_DIGITS = 3'h2;
    localparam logic [2:0] LINK_LAST_FIELD = 3'h3;
    localparam logic [2:0] PIN_LAST_FIELD = 3'h1;
    localparam logic [1:0] ESC_LAST = 2'h2;

    // ------------------------------------------------------------------
    // link parameter ranges and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] INTV_MIN = 16'h0006;
    localparam logic [15:0] INTV_MAX = 16'h0C80;
    localparam logic [15:0] LAT_MAX = 16'h01F3;
    localparam logic [15:0] TMO_MIN = 16'h000A;
    localparam logic [15:0] TMO_MAX = 16'h0C80;
    // timeout unit 10 ms over interval unit 1.25 ms
    localparam logic [3:0] TMO_SHIFT = 4'h3;
    localparam logic [15:0] RST_MIN_INTV = 16'h0006;
    localparam logic [15:0] RST_MAX_INTV = 16'h0006;
    localparam logic [15:0] RST_LATENCY = 16'h0000;
    localparam logic [15:0] RST_TIMEOUT = 16'h0200;

    // ------------------------------------------------------------------
    // pin functions
    // ------------------------------------------------------------------
    localparam int PIN_COUNT = 14;
    localparam logic [7:0] PIN_LIMIT = 8'h0E;
    localparam logic [3:0] FN_NONE = 4'h0;
    localparam logic [3:0] FN_LOW_BATT = 4'h1;
    localparam logic [3:0] FN_SIGNAL_STRENGTH = 4'h2;
    localparam logic [3:0] FN_LINK_DROP = 4'h3;
    localparam logic [3:0] FN_RX_IND = 4'h4;
    localparam logic [3:0] FN_PAIRING = 4'h5;
    localparam logic [3:0] FN_RADIO_ACTIVE = 4'h6;
    localparam logic [3:0] FN_STATUS1 = 4'h7;
    localparam logic [3:0] FN_STATUS2 = 4'h8;
    localparam logic [3:0] FN_TRIG1 = 4'h9;
    localparam logic [3:0] FN_TRIG2 = 4'hA;
    localparam logic [3:0] FN_TRIG3 = 4'hB;
    localparam logic [3:0] FN_MODE_SWITCH = 4'hC;
    localparam logic [7:0] FN_LIMIT = 8'h0C;

    // reset function of each pin, index 0 in the low nibble
    localparam logic [55:0] PIN_RST_FUNCS = {
        FN_NONE, FN_RX_IND, FN_NONE, FN_NONE, FN_NONE, FN_PAIRING, FN_RX_IND,
        FN_LINK_DROP, FN_SIGNAL_STRENGTH, FN_NONE, FN_NONE, FN_STATUS1,
        FN_STATUS2, FN_LOW_BATT};
    // pins that carry no function after reset
    localparam logic [13:0] PIN_RST_FREE = 14'h2E18;
    // no pin is a mode switch after reset
    localparam logic [13:0] PIN_RST_MODE = 14'h0000;

endpackage : cpp_pkg

// *** cpp_pin_table.sv ***
// pin-function table: one function nibble per pin, registered read port
module cpp_pin_table
    import cpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [3:0] wr_func,
    input wire logic [3:0] rd_idx,
    output logic [3:0] rd_func
);

    logic [3:0] entry [PIN_COUNT];

    // ------------------------------------------------------------------
    // storage, each entry resets to its own default function
    // ------------------------------------------------------------------
    for (genvar i = 0; i < PIN_COUNT; i++)
    begin : g_entry
        always_ff @(posedge core_clk or negedge rstn)
        begin
            if (!rstn)
                entry[i] <= PIN_RST_FUNCS[4*i +: 4];
            else if (wr_en && (wr_idx == 4'(i)))
                entry[i] <= wr_func;
        end
    end

    // read port; out of range reads as no function
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rd_func <= FN_NONE;
        else if (rd_idx < 4'(PIN_COUNT))
            rd_func <= entry[rd_idx];
        else
            rd_func <= FN_NONE;
    end

endmodule : cpp_pin_table

// *** cpp_cmd.sv ***
// command interpreter for the link-parameter and pin-function commands
// Function
// - link command takes four hex16 values
// - stored values only seed future central links
// - minimum interval 0x0006..0x0C80, unit 1.25 ms
// - maximum interval same range, not below minimum
// - timeout 0x000A..0x0C80, unit 10 ms
// - read-back shows stored or live link values
// - answer ok or error for each command
// - pin command takes pin, then function hex8
// - function codes 00 to 0C decode
// - pins 00..06 reset to listed functions
// - function 0C pin edges switch modes
// - fast mode disables escape scan in data
// - pin with no function may be analog
module cpp_cmd
    import cpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic fast_mode,
    input wire logic connected,
    input wire logic [15:0] live_min_intv,
    input wire logic [15:0] live_max_intv,
    input wire logic [15:0] live_latency,
    input wire logic [15:0] live_timeout,
    input wire logic [13:0] pin_in,
    input wire logic [3:0] pin_query_idx,
    output logic [3:0] pin_query_func,
    output logic cmd_mode,
    output logic reply_valid,
    output logic reply_ok,
    output logic [15:0] init_min_intv,
    output logic [15:0] init_max_intv,
    output logic [15:0] init_latency,
    output logic [15:0] init_timeout,
    output logic [15:0] rpt_min_intv,
    output logic [15:0] rpt_max_intv,
    output logic [15:0] rpt_latency,
    output logic [15:0] rpt_timeout,
    output logic [13:0] analog_free
);

    // ------------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_LETTER = 3'b001,
        ST_COMMA = 3'b010,
        ST_HEX = 3'b011,
        ST_SKIP = 3'b100
    } cpp_state_e;

    typedef struct packed
    {
        cpp_state_e st;
        logic is_pin;
        logic [2:0] fld;
        logic [2:0] ndig;
        logic [15:0] acc;
        logic [15:0] f0;
        logic [15:0] f1;
        logic [15:0] f2;
        logic [15:0] min_intv;
        logic [15:0] max_intv;
        logic [15:0] latency;
        logic [15:0] timeout;
        logic [15:0] r_min;
        logic [15:0] r_max;
        logic [15:0] r_lat;
        logic [15:0] r_tmo;
        logic rep_v;
        logic rep_ok;
        logic cmd_mode;
        logic [1:0] esc_cnt;
        logic [13:0] sync1;
        logic [13:0] sync2;
        logic [13:0] prev;
        logic [13:0] mode_mask;
        logic [13:0] free_mask;
        logic wr_en;
        logic [3:0] wr_idx;
        logic [3:0] wr_func;
    } cpp_regs_s;

    cpp_regs_s r;
    cpp_regs_s next_r;

    // hex character to nibble, top bit flags a valid digit
    function automatic logic [4:0] hex_digit(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
            hex_digit = {1'b1, 4'(c - 8'h30)};
        else if (c >= 8'h41 && c <= 8'h46)
            hex_digit = {1'b1, 4'(c - 8'h37)};
        else if (c >= 8'h61 && c <= 8'h66)
            hex_digit = {1'b1, 4'(c - 8'h57)};
        else
            hex_digit = 5'h00;
    endfunction : hex_digit

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [4:0] dig;
        logic [2:0] max_dig;
        logic [2:0] last_fld;
        logic [31:0] lat_prod;
        logic [31:0] tmo_lim;
        logic link_ok;
        logic pin_ok;
        logic [13:0] rise;
        logic [13:0] fall;
        dig = hex_digit(rx_byte);
        max_dig = r.is_pin ? PIN_DIGITS : LINK_DIGITS;
        last_fld = r.is_pin ? PIN_LAST_FIELD : LINK_LAST_FIELD;
        // latency+1 times interval must stay under timeout scaled to interval units
        lat_prod = (32'(r.f2) + 32'h1) * 32'(r.f1);
        tmo_lim = 32'(r.acc) << TMO_SHIFT;
        link_ok = (r.f0 >= INTV_MIN) && (r.f0 <= INTV_MAX)
            && (r.f1 >= INTV_MIN) && (r.f1 <= INTV_MAX) && (r.f1 >= r.f0)
            && (r.f2 <= LAT_MAX) && (lat_prod < tmo_lim)
            && (r.acc >= TMO_MIN) && (r.acc <= TMO_MAX);
        pin_ok = (r.f0 < 16'(PIN_LIMIT)) && (r.acc <= 16'(FN_LIMIT));
        rise = r.sync2 & ~r.prev & r.mode_mask;
        fall = ~r.sync2 & r.prev & r.mode_mask;

        next_r = r;
        next_r.rep_v = 1'b0;
        next_r.wr_en = 1'b0;

        // pin synchronisers; the second stage and its delayed copy prev feed edge logic
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;

        // read-back follows the live link once connected
        if (connected)
        begin
            next_r.r_min = live_min_intv;
            next_r.r_max = live_max_intv;
            next_r.r_lat = live_latency;
            next_r.r_tmo = live_timeout;
        end
        else
        begin
            next_r.r_min = r.min_intv;
            next_r.r_max = r.max_intv;
            next_r.r_lat = r.latency;
            next_r.r_tmo = r.timeout;
        end

        // data mode: watch for the escape string unless fast mode is on
        if (!r.cmd_mode && rx_valid)
        begin
            if (fast_mode || rx_byte != CH_ESC)
                next_r.esc_cnt = 2'h0;
            else if (r.esc_cnt == ESC_LAST)
            begin
                next_r.esc_cnt = 2'h0;
                next_r.cmd_mode = 1'b1;
                next_r.st = ST_IDLE;
            end
            else
                next_r.esc_cnt = r.esc_cnt + 2'h1;
        end
        else if (r.cmd_mode && rx_valid)
        begin
            case (r.st)
                ST_IDLE:
                    if (rx_byte == CH_S)
                        next_r.st = ST_LETTER;
                    else if (rx_byte != CH_CR)
                        next_r.st = ST_SKIP;
                ST_LETTER:
                begin
                    next_r.is_pin = (rx_byte == CH_W);
                    if (rx_byte == CH_T || rx_byte == CH_W)
                        next_r.st = ST_COMMA;
                    else if (rx_byte == CH_CR)
                    begin
                        next_r.st = ST_IDLE;
                        next_r.rep_v = 1'b1;
                        next_r.rep_ok = 1'b0;
                    end
                    else
                        next_r.st = ST_SKIP;
                end
                ST_COMMA:
                begin
                    next_r.fld = 3'h0;
                    next_r.ndig = 3'h0;
                    next_r.acc = 16'h0000;
                    if (rx_byte == CH_COMMA)
                        next_r.st = ST_HEX;
                    else if (rx_byte == CH_CR)
                    begin
                        next_r.st = ST_IDLE;
                        next_r.rep_v = 1'b1;
                        next_r.rep_ok = 1'b0;
                    end
                    else
                        next_r.st = ST_SKIP;
                end
                ST_HEX:
                    if (dig[4] && r.ndig < max_dig)
                    begin
                        next_r.acc = {r.acc[11:0], dig[3:0]};
                        next_r.ndig = r.ndig + 3'h1;
                    end
                    else if (rx_byte == CH_COMMA && r.ndig != 3'h0 && r.fld != last_fld)
                    begin
                        if (r.fld == 3'h0)
                            next_r.f0 = r.acc;
                        else if (r.fld == 3'h1)
                            next_r.f1 = r.acc;
                        else
                            next_r.f2 = r.acc;
                        next_r.fld = r.fld + 3'h1;
                        next_r.ndig = 3'h0;
                        next_r.acc = 16'h0000;
                    end
                    else if (rx_byte == CH_CR)
                    begin
                        next_r.st = ST_IDLE;
                        next_r.rep_v = 1'b1;
                        next_r.rep_ok = 1'b0;
                        if (r.ndig != 3'h0 && r.fld == last_fld)
                        begin
                            if (r.is_pin && pin_ok)
                            begin
                                // table and masks change only on a good command
                                next_r.rep_ok = 1'b1;
                                next_r.wr_en = 1'b1;
                                next_r.wr_idx = r.f0[3:0];
                                next_r.wr_func = r.acc[3:0];
                                next_r.mode_mask[r.f0[3:0]] = (r.acc[3:0] == FN_MODE_SWITCH);
                                next_r.free_mask[r.f0[3:0]] = (r.acc[3:0] == FN_NONE);
                            end
                            else if (!r.is_pin && link_ok)
                            begin
                                // only the seed for later links; the live link is untouched
                                next_r.rep_ok = 1'b1;
                                next_r.min_intv = r.f0;
                                next_r.max_intv = r.f1;
                                next_r.latency = r.f2;
                                next_r.timeout = r.acc;
                            end
                        end
                    end
                    else
                        next_r.st = ST_SKIP;
                ST_SKIP:
                    if (rx_byte == CH_CR)
                    begin
                        next_r.st = ST_IDLE;
                        next_r.rep_v = 1'b1;
                        next_r.rep_ok = 1'b0;
                    end
                default:
                    next_r.st = ST_IDLE;
            endcase
        end

        // mode-switch pin edges take priority over byte handling
        if (|rise)
        begin
            next_r.cmd_mode = 1'b0;
            next_r.esc_cnt = 2'h0;
        end
        else if (|fall)
        begin
            next_r.cmd_mode = 1'b1;
            next_r.st = ST_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.cmd_mode <= 1'b1;
            r.min_intv <= RST_MIN_INTV;
            r.max_intv <= RST_MAX_INTV;
            r.latency <= RST_LATENCY;
            r.timeout <= RST_TIMEOUT;
            r.r_min <= RST_MIN_INTV;
            r.r_max <= RST_MAX_INTV;
            r.r_lat <= RST_LATENCY;
            r.r_tmo <= RST_TIMEOUT;
            r.mode_mask <= PIN_RST_MODE;
            r.free_mask <= PIN_RST_FREE;
        end
        else
            r <= next_r;
    end

    // pin-function storage
    cpp_pin_table u_table (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_en(r.wr_en),
        .wr_idx(r.wr_idx),
        .wr_func(r.wr_func),
        .rd_idx(pin_query_idx),
        .rd_func(pin_query_func)
    );

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign cmd_mode = r.cmd_mode;
    assign reply_valid = r.rep_v;
    assign reply_ok = r.rep_ok;
    assign init_min_intv = r.min_intv;
    assign init_max_intv = r.max_intv;
    assign init_latency = r.latency;
    assign init_timeout = r.timeout;
    assign rpt_min_intv = r.r_min;
    assign rpt_max_intv = r.r_max;
    assign rpt_latency = r.r_lat;
    assign rpt_timeout = r.r_tmo;
    assign analog_free = r.free_mask;

endmodule : cpp_cmd

// *** cpp_cmd_asserts.sv ***
// assertion checker watching the command interpreter ports
module cpp_cmd_asserts
    import cpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic connected,
    input wire logic [15:0] live_timeout,
    input wire logic cmd_mode,
    input wire logic reply_valid,
    input wire logic reply_ok,
    input wire logic [15:0] init_min_intv,
    input wire logic [15:0] init_max_intv,
    input wire logic [15:0] init_latency,
    input wire logic [15:0] init_timeout,
    input wire logic [15:0] rpt_min_intv,
    input wire logic [15:0] rpt_timeout,
    input wire logic [13:0] analog_free
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // clocking and helper logic
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // widened so the latency bound product cannot wrap
    logic [31:0] lat_span;
    logic [31:0] tmo_span;
    assign lat_span = (32'(init_latency) + 32'h1) * 32'(init_max_intv);
    assign tmo_span = 32'(init_timeout) << 3;

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_reply_cause;
        reply_valid |-> $past(rx_valid && rx_byte == CH_CR && cmd_mode);
    endproperty
    a_reply_cause: assert property (p_reply_cause) else $error("reply without CR");
    property p_reply_pulse;
        reply_valid |=> !reply_valid;
    endproperty
    a_reply_pulse: assert property (p_reply_pulse) else $error("reply too long");
    property p_min_rng;
        init_min_intv >= INTV_MIN && init_min_intv <= INTV_MAX;
    endproperty
    a_min_rng: assert property (p_min_rng) else $error("min out of range");
    property p_max_rng;
        init_max_intv <= INTV_MAX && init_max_intv >= init_min_intv;
    endproperty
    a_max_rng: assert property (p_max_rng) else $error("max out of range");
    property p_lat;
        init_latency <= LAT_MAX && lat_span < tmo_span;
    endproperty
    a_lat: assert property (p_lat) else $error("latency out of range");
    property p_tmo;
        init_timeout >= TMO_MIN && init_timeout <= TMO_MAX;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout out of range");
    property p_seed_upd;
        !$stable({init_min_intv, init_max_intv, init_latency, init_timeout})
            |-> reply_valid && reply_ok;
    endproperty
    a_seed_upd: assert property (p_seed_upd) else $error("seed changed alone");
    property p_rpt_stored;
        !$past(connected) |-> rpt_min_intv == $past(init_min_intv)
            && rpt_timeout == $past(init_timeout);
    endproperty
    a_rpt_stored: assert property (p_rpt_stored) else $error("stored readback");
    property p_rpt_live;
        $past(connected) |-> rpt_timeout == $past(live_timeout);
    endproperty
    a_rpt_live: assert property (p_rpt_live) else $error("live readback");
    // the free mask moves on the same edge that raises the reply, so look there
    property p_bad_keep;
        reply_valid && !reply_ok |-> $stable(analog_free);
    endproperty
    a_bad_keep: assert property (p_bad_keep) else $error("table changed on error");
    c_ok: cover property (reply_valid && reply_ok);
    c_err: cover property (reply_valid && !reply_ok);
    c_data: cover property ($fell(cmd_mode));
endmodule : cpp_cmd_asserts

// *** cpp_host_model.sv ***
// host model sending command characters to the interpreter
module cpp_host_model
    import cpp_pkg::*;
(
    input wire logic core_clk,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle after reset
    initial
    begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    // one character a cycle, back to back; idle byte is the inverse of
    // the last one so a stale value can never look like a fresh match
    task automatic send(input string s, input bit cr);
        logic [7:0] c;
        for (int i = 0; i < s.len() + int'(cr); i++)
        begin
            c = (i == s.len()) ? CH_CR : 8'(s[i]);
            @(negedge core_clk);
            rx_byte = c;
            rx_valid = 1'b1;
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
    endtask : send
endmodule : cpp_host_model

// *** testbench.sv ***
// self-checking bench for the link-parameter and pin-function commands
module testbench
    import cpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rx_valid, cmd_mode, reply_valid, reply_ok;
    logic rstn = 1'b0;
    logic fast_mode = 1'b0;
    logic connected = 1'b0;
    logic [7:0] rx_byte;
    logic [63:0] live = 64'h0011_0022_0003_0444;
    logic [13:0] pin_in = 14'h0000;
    logic [13:0] analog_free;
    logic [3:0] pin_query_idx = 4'h0;
    logic [3:0] pin_query_func;
    logic [15:0] init_min_intv, init_max_intv, init_latency, init_timeout;
    logic [15:0] rpt_min_intv, rpt_max_intv, rpt_latency, rpt_timeout;
    logic [3:0] rst_fn [7] = '{4'h1, 4'h8, 4'h7, 4'h0, 4'h0, 4'h2, 4'h3};
    string good [3] = '{"ST,0010,0C7F,0001,0C80", "ST,0006,0006,01F3,0C80",
        "ST,0064,0064,0006,0064"};
    logic [63:0] gv [3] = '{64'h0010_0C7F_0001_0C80, 64'h0006_0006_01F3_0C80,
        64'h0064_0064_0006_0064};
    string bad [11] = '{"ST,0005,0064,0000,0064", "ST,0C81,0C81,0000,0C80",
        "ST,0064,0063,0000,0064", "ST,0064,0C81,0000,0C80", "ST,0006,0006,01F4,0C80",
        "ST,0064,0064,0007,0064", "ST,0064,0064,0000,0009", "ST,0064,0064,0000,0C81",
        "ST,0064,0064,0002", "SX,0064", "ST,00064,0064,0000,0064"};
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    cpp_host_model host (.core_clk(core_clk), .rx_byte(rx_byte), .rx_valid(rx_valid));
    cpp_cmd DUT (.core_clk(core_clk), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .fast_mode(fast_mode), .connected(connected), .live_min_intv(live[63:48]),
        .live_max_intv(live[47:32]), .live_latency(live[31:16]), .live_timeout(live[15:0]),
        .pin_in(pin_in), .pin_query_idx(pin_query_idx), .pin_query_func(pin_query_func),
        .cmd_mode(cmd_mode), .reply_valid(reply_valid), .reply_ok(reply_ok),
        .init_min_intv(init_min_intv), .init_max_intv(init_max_intv),
        .init_latency(init_latency), .init_timeout(init_timeout),
        .rpt_min_intv(rpt_min_intv), .rpt_max_intv(rpt_max_intv),
        .rpt_latency(rpt_latency), .rpt_timeout(rpt_timeout), .analog_free(analog_free));

    // ------------------------------------------------------------------
    // clock, run limit and shared tasks
    // ------------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // a hang shows up as a mismatch rather than a stuck run
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("[ERR] %0t run limit reached", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n
    // send one line and expect an answer within four cycles after the CR
    task automatic cmd(input string s, input logic ok);
        logic seen;
        seen = 1'b0;
        host.send(s, 1'b1);
        for (int i = 0; i < 4 && !seen; i++)
        begin
            if (reply_valid === 1'b1)
                seen = 1'b1;
            else
                @(negedge core_clk);
        end
        chk(seen, 1'b1, {s, " answer"});
        chk(reply_ok, ok, {s, " status"});
    endtask : cmd
    // stored seed and its readback, which lags by one edge
    task automatic link(input logic [63:0] v);
        wait_n(1);
        chk({init_min_intv, init_max_intv, init_latency, init_timeout}, v, "seed");
        chk({rpt_min_intv, rpt_max_intv, rpt_latency, rpt_timeout}, v, "readback");
    endtask : link
    task automatic query(input logic [3:0] idx, input logic [3:0] exp);
        pin_query_idx = idx;
        wait_n(2);
        chk(pin_query_func, exp, "pin function");
    endtask : query
    task automatic wait_mode(input logic exp);
        for (int i = 0; i < 8 && cmd_mode !== exp; i++)
            @(negedge core_clk);
        chk(cmd_mode, exp, "mode");
    endtask : wait_mode

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        wait_n(2);
        rstn = 1'b1;
        link({RST_MIN_INTV, RST_MAX_INTV, RST_LATENCY, RST_TIMEOUT});
        chk(analog_free, PIN_RST_FREE, "free pins");
        chk(cmd_mode, 1'b1, "reset mode");
        for (int i = 0; i < 7; i++)
            query(4'(i), rst_fn[i]);
        for (int i = 0; i < 3; i++)
        begin
            cmd(good[i], 1'b1);
            link(gv[i]);
        end
        for (int i = 0; i < 11; i++)
        begin
            cmd(bad[i], 1'b0);
            link(gv[2]);
        end
        connected = 1'b1;
        // values inside the host's phone-friendly envelope
        cmd("ST,0020,0040,0000,0100", 1'b1);
        wait_n(1);
        chk({rpt_min_intv, rpt_max_intv, rpt_latency, rpt_timeout}, live, "live");
        chk({init_min_intv, init_timeout}, 32'h0020_0100, "seed while linked");
        connected = 1'b0;
        link(64'h0020_0040_0000_0100);
        for (int f = 0; f <= 12; f++)
        begin
            cmd($sformatf("SW,04,%02X", f), 1'b1);
            query(4'h4, 4'(f));
        end
        cmd("SW,04,00", 1'b1);
        cmd("SW,03,06", 1'b1);
        query(4'h3, 4'h6);
        cmd("SW,0E,01", 1'b0);
        cmd("SW,03,0D", 1'b0);
        query(4'h3, 4'h6);
        cmd("SW,02,00", 1'b1);
        wait_n(2);
        chk(analog_free, 14'h2E14, "free pins");
        cmd("SW,0A,0C", 1'b1);
        pin_in[10] = 1'b1;
        wait_mode(1'b0);
        fast_mode = 1'b1;
        host.send("$$$", 1'b0);
        wait_n(6);
        chk(cmd_mode, 1'b0, "escape ignored");
        fast_mode = 1'b0;
        host.send("$$$", 1'b0);
        wait_mode(1'b1);
        pin_in[10] = 1'b0;
        wait_n(6);
        pin_in[10] = 1'b1;
        wait_mode(1'b0);
        pin_in[10] = 1'b0;
        wait_mode(1'b1);
        end_sim();
    end
endmodule : testbench

bind cpp_cmd cpp_cmd_asserts u_chk (.core_clk(core_clk), .rstn(rstn), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .connected(connected), .live_timeout(live_timeout),
    .cmd_mode(cmd_mode), .reply_valid(reply_valid), .reply_ok(reply_ok),
    .init_min_intv(init_min_intv), .init_max_intv(init_max_intv),
    .init_latency(init_latency), .init_timeout(init_timeout),
    .rpt_min_intv(rpt_min_intv), .rpt_timeout(rpt_timeout), .analog_free(analog_free));
